// ### core/pbm_pkg.sv
// Contract
// - Host reaches registers only by index, indirectly.
// - Decode indexes 0-6, 17, 18, 27, 29-31.
// - Kept fields survive only the software reset.
// - Control bit 15 starts self-clearing software reset.
// - Control bit 14 selects loopback, resets zero.
// - Manual speed bit 13 used only without negotiation.
// - Control bit 12 enables negotiation, overriding manual.
// - Bit 11 powers down; renegotiation sets status 5.
// - Control bit 9 restarts negotiation, self-clears.
// - Manual duplex bit 8 used only without negotiation.
// - Control bit 7 enables collision test, resets zero.
// - Speed and negotiation reset values follow strap.
// - Status 15..11 fixed abilities 0,1,1,1,1.
// - Status bit 5 shows negotiation complete.
// - Status bit 4 latches high on remote fault.
// - Status bit 3 always reads one.
// - Status bit 2 link, latches low on drop.
// - Status bit 1 latches high on jabber.
// - Status bit 0 always reads one.
package pbm_pkg;

    // ****************************************
    // Index map
    // ****************************************
    localparam logic [4:0] IDX_CONTROL     = 5'h00;
    localparam logic [4:0] IDX_STATUS      = 5'h01;
    localparam logic [4:0] IDX_IDENT_HIGH  = 5'h02;
    localparam logic [4:0] IDX_IDENT_LOW   = 5'h03;
    localparam logic [4:0] IDX_ADVERTISE   = 5'h04;
    localparam logic [4:0] IDX_PARTNER     = 5'h05;
    localparam logic [4:0] IDX_EXPANSION   = 5'h06;
    localparam logic [4:0] IDX_MODE_CTRL   = 5'h11;
    localparam logic [4:0] IDX_SPEC_MODES  = 5'h12;
    localparam logic [4:0] IDX_SPEC_IND    = 5'h1B;
    localparam logic [4:0] IDX_INT_SOURCE  = 5'h1D;
    localparam logic [4:0] IDX_INT_MASK    = 5'h1E;
    localparam logic [4:0] IDX_SPEC_CTRL   = 5'h1F;

    // ****************************************
    // Control and status fields
    // ****************************************
    localparam int CTL_RESET     = 15;
    localparam int CTL_LOOPBACK  = 14;
    localparam int CTL_SPEED     = 13;
    localparam int CTL_NEG_EN    = 12;
    localparam int CTL_PWR_DOWN  = 11;
    localparam int CTL_RESTART   = 9;
    localparam int CTL_DUPLEX    = 8;
    localparam int CTL_COL_TEST  = 7;
    localparam int STS_NEG_DONE  = 5;
    localparam int STS_RFAULT    = 4;
    localparam int STS_LINK      = 2;
    localparam int STS_JABBER    = 1;
    localparam logic [15:0] STS_FIXED   = 16'h7809;
    localparam logic [15:0] KEPT_OVER_SOFT_RESET = 16'h0000;
    // Arbitrary identifier values
    localparam logic [15:0] IDENT_HIGH_VALUE = 16'h1234;
    localparam logic [15:0] IDENT_LOW_VALUE  = 16'h5678;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_HZ           = 10_000_000;
    localparam int SOFT_RESET_TIME_NS = 1000;
    localparam int SOFT_RESET_CYCLES  =
        (SOFT_RESET_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int NEG_TIME_MS        = 1;
    localparam int NEG_CYCLES_DEF     = NEG_TIME_MS * (CLOCK_HZ / 1000);

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic        write;
        logic [4:0]  index;
        logic [15:0] wdata;
    } pbm_acc_req_s;

    typedef struct packed {
        logic        done;
        logic        unmapped;
        logic [15:0] rdata;
    } pbm_acc_rsp_s;

    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
        logic partner_100;
        logic partner_full;
    } pbm_line_s;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic full_duplex;
        logic power_down;
        logic col_test;
        logic neg_enable;
        logic neg_complete;
        logic soft_reset;
    } pbm_mode_s;

    typedef enum logic [1:0] {
        NEG_IDLE = 2'b00,
        NEG_WAIT = 2'b01,
        NEG_DONE = 2'b10
    } pbm_neg_e;

endpackage : pbm_pkg

// ### core/pbm_sync.sv
`timescale 1ns/1ns
module pbm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage_one;

    // ****************************************
    // Two flops per bit
    // ****************************************
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge i_clock) begin
            stage_one[b] <= i_async[b];
            o_sync[b]    <= stage_one[b];
        end
    end

endmodule : pbm_sync

// ### core/pbm_negotiate.sv
`timescale 1ns/1ns
module pbm_negotiate #(
    parameter int NEG_CYCLES = pbm_pkg::NEG_CYCLES_DEF
) (
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_enable,
    input  wire logic i_start,
    input  wire logic i_hold,
    input  wire logic i_link_up,
    output logic      o_complete
);

    pbm_pkg::pbm_neg_e state;
    logic [31:0]       count;

    // ****************************************
    // Negotiation sequence
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !i_enable || i_hold || i_start) begin
            state <= pbm_pkg::NEG_IDLE;
            count <= '0;
        end else begin
            case (state)
                pbm_pkg::NEG_IDLE: begin
                    state <= pbm_pkg::NEG_WAIT;
                    count <= '0;
                end
                pbm_pkg::NEG_WAIT: begin
                    if (!i_link_up) begin
                        count <= '0;
                    end else if (count >= 32'(NEG_CYCLES - 1)) begin
                        state <= pbm_pkg::NEG_DONE;
                    end else begin
                        count <= count + 32'h1;
                    end
                end
                pbm_pkg::NEG_DONE: begin
                    if (!i_link_up) begin
                        state <= pbm_pkg::NEG_WAIT;
                        count <= '0;
                    end
                end
                default: state <= pbm_pkg::NEG_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_complete <= 1'b0;
        end else begin
            o_complete <= i_enable && !i_hold && !i_start
                          && state == pbm_pkg::NEG_DONE;
        end
    end

endmodule : pbm_negotiate

// ### core/pbm_regs.sv
`timescale 1ns/1ns
module pbm_regs #(
    parameter int NEG_CYCLES = pbm_pkg::NEG_CYCLES_DEF
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_sys_rst,
    input  wire logic                  i_acc_valid,
    input  wire pbm_pkg::pbm_acc_req_s i_acc_req,
    input  wire logic                  i_speed_strap,
    input  wire pbm_pkg::pbm_line_s    i_line,
    output pbm_pkg::pbm_acc_rsp_s      o_acc_rsp,
    output pbm_pkg::pbm_mode_s         o_mode
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    pbm_pkg::pbm_line_s line_s;
    logic               strap_s;

    pbm_sync #(
        .WIDTH ($bits(pbm_pkg::pbm_line_s) + 1)
    ) u_sync (
        .i_clock (i_clock),
        .i_async ({i_line, i_speed_strap}),
        .o_sync  ({line_s, strap_s})
    );

    // ****************************************
    // Access decode
    // ****************************************
    logic        acc_wr;
    logic        acc_rd;
    logic        ctrl_wr;
    logic        stat_rd;
    logic        soft_start;
    logic [15:0] wdata;

    assign wdata   = i_acc_req.wdata;
    assign acc_wr  = i_acc_valid && i_acc_req.write;
    assign acc_rd  = i_acc_valid && !i_acc_req.write;
    assign ctrl_wr = acc_wr && i_acc_req.index == pbm_pkg::IDX_CONTROL;
    assign stat_rd = acc_rd && i_acc_req.index == pbm_pkg::IDX_STATUS;
    assign soft_start = ctrl_wr && wdata[pbm_pkg::CTL_RESET];

    // ****************************************
    // Control fields
    // ****************************************
    logic loopback;
    logic speed_sel;
    logic neg_en;
    logic pwr_down;
    logic duplex_sel;
    logic col_test;
    logic restart;
    logic rst_busy;

    logic [15:0] ctrl_word;
    logic [15:0] ctrl_reset_word;
    logic [15:0] next_ctrl;

    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[pbm_pkg::CTL_RESET]    = rst_busy;
        ctrl_word[pbm_pkg::CTL_LOOPBACK] = loopback;
        ctrl_word[pbm_pkg::CTL_SPEED]    = speed_sel;
        ctrl_word[pbm_pkg::CTL_NEG_EN]   = neg_en;
        ctrl_word[pbm_pkg::CTL_PWR_DOWN] = pwr_down;
        ctrl_word[pbm_pkg::CTL_RESTART]  = restart;
        ctrl_word[pbm_pkg::CTL_DUPLEX]   = duplex_sel;
        ctrl_word[pbm_pkg::CTL_COL_TEST] = col_test;
    end

    always_comb begin
        ctrl_reset_word = 16'h0000;
        ctrl_reset_word[pbm_pkg::CTL_SPEED]  = strap_s;
        ctrl_reset_word[pbm_pkg::CTL_NEG_EN] = strap_s;
    end

    // Kept fields hold their value over the software reset only
    assign next_ctrl = (ctrl_word & pbm_pkg::KEPT_OVER_SOFT_RESET)
                     | (ctrl_reset_word & ~pbm_pkg::KEPT_OVER_SOFT_RESET);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            loopback   <= 1'b0;
            speed_sel  <= strap_s;
            neg_en     <= strap_s;
            pwr_down   <= 1'b0;
            duplex_sel <= 1'b0;
            col_test   <= 1'b0;
        end else if (soft_start) begin
            loopback   <= next_ctrl[pbm_pkg::CTL_LOOPBACK];
            speed_sel  <= next_ctrl[pbm_pkg::CTL_SPEED];
            neg_en     <= next_ctrl[pbm_pkg::CTL_NEG_EN];
            pwr_down   <= next_ctrl[pbm_pkg::CTL_PWR_DOWN];
            duplex_sel <= next_ctrl[pbm_pkg::CTL_DUPLEX];
            col_test   <= next_ctrl[pbm_pkg::CTL_COL_TEST];
        end else if (ctrl_wr) begin
            loopback   <= wdata[pbm_pkg::CTL_LOOPBACK];
            speed_sel  <= wdata[pbm_pkg::CTL_SPEED];
            neg_en     <= wdata[pbm_pkg::CTL_NEG_EN];
            pwr_down   <= wdata[pbm_pkg::CTL_PWR_DOWN];
            duplex_sel <= wdata[pbm_pkg::CTL_DUPLEX];
            col_test   <= wdata[pbm_pkg::CTL_COL_TEST];
        end
    end

    // ****************************************
    // Self-clearing restart and reset
    // ****************************************
    logic [7:0] rst_count;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            restart <= 1'b0;
        end else begin
            restart <= ctrl_wr && !soft_start
                       && wdata[pbm_pkg::CTL_RESTART];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rst_busy  <= 1'b0;
            rst_count <= 8'h00;
        end else if (soft_start) begin
            rst_busy  <= 1'b1;
            rst_count <= 8'(pbm_pkg::SOFT_RESET_CYCLES - 1);
        end else if (rst_busy) begin
            if (rst_count == 8'h00) begin
                rst_busy <= 1'b0;
            end else begin
                rst_count <= rst_count - 8'h01;
            end
        end
    end

    // ****************************************
    // Negotiation
    // ****************************************
    logic neg_done;

    pbm_negotiate #(
        .NEG_CYCLES (NEG_CYCLES)
    ) u_negotiate (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_enable   (neg_en),
        .i_start    (restart || soft_start),
        .i_hold     (pwr_down || rst_busy),
        .i_link_up  (line_s.link_up),
        .o_complete (neg_done)
    );

    // ****************************************
    // Latched status
    // ****************************************
    logic rfault_latch;
    logic jabber_latch;
    logic link_latch;
    logic clr_latch;

    assign clr_latch = soft_start;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || clr_latch) begin
            rfault_latch <= 1'b0;
        end else if (line_s.remote_fault) begin
            rfault_latch <= 1'b1;
        end else if (stat_rd) begin
            rfault_latch <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || clr_latch) begin
            jabber_latch <= 1'b0;
        end else if (line_s.jabber) begin
            jabber_latch <= 1'b1;
        end else if (stat_rd) begin
            jabber_latch <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || clr_latch) begin
            link_latch <= 1'b0;
        end else if (!line_s.link_up) begin
            link_latch <= 1'b0;
        end else if (stat_rd) begin
            link_latch <= 1'b1;
        end
    end

    logic [15:0] stat_word;

    always_comb begin
        stat_word = pbm_pkg::STS_FIXED;
        stat_word[pbm_pkg::STS_NEG_DONE] = neg_done;
        stat_word[pbm_pkg::STS_RFAULT]   = rfault_latch;
        stat_word[pbm_pkg::STS_LINK]     = link_latch;
        stat_word[pbm_pkg::STS_JABBER]   = jabber_latch;
    end

    // ****************************************
    // Read data
    // ****************************************
    logic [15:0] next_rdata;
    logic        next_unmapped;
    logic [4:0]  idx;

    assign idx = i_acc_req.index;

    always_comb begin
        next_rdata    = 16'h0000;
        next_unmapped = 1'b0;
        if (idx == pbm_pkg::IDX_CONTROL) begin
            next_rdata = ctrl_word;
        end else if (idx == pbm_pkg::IDX_STATUS) begin
            next_rdata = stat_word;
        end else if (idx == pbm_pkg::IDX_IDENT_HIGH) begin
            next_rdata = pbm_pkg::IDENT_HIGH_VALUE;
        end else if (idx == pbm_pkg::IDX_IDENT_LOW) begin
            next_rdata = pbm_pkg::IDENT_LOW_VALUE;
        end else if (idx == pbm_pkg::IDX_ADVERTISE
                  || idx == pbm_pkg::IDX_PARTNER
                  || idx == pbm_pkg::IDX_EXPANSION
                  || idx == pbm_pkg::IDX_MODE_CTRL
                  || idx == pbm_pkg::IDX_SPEC_MODES
                  || idx == pbm_pkg::IDX_SPEC_IND
                  || idx == pbm_pkg::IDX_INT_SOURCE
                  || idx == pbm_pkg::IDX_INT_MASK
                  || idx == pbm_pkg::IDX_SPEC_CTRL) begin
            next_rdata = 16'h0000;
        end else begin
            next_unmapped = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_acc_rsp <= '0;
        end else begin
            o_acc_rsp.done     <= i_acc_valid;
            o_acc_rsp.unmapped <= i_acc_valid && next_unmapped;
            if (acc_rd) begin
                o_acc_rsp.rdata <= next_rdata;
            end
        end
    end

    // ****************************************
    // Operating mode
    // ****************************************
    logic next_speed;
    logic next_duplex;

    always_comb begin
        if (neg_en) begin
            next_speed  = neg_done && line_s.partner_100;
            next_duplex = neg_done && line_s.partner_full;
        end else begin
            next_speed  = speed_sel;
            next_duplex = duplex_sel;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_mode <= '0;
        end else begin
            o_mode.loopback     <= loopback;
            o_mode.speed_100    <= next_speed;
            o_mode.full_duplex  <= next_duplex;
            o_mode.power_down   <= pwr_down;
            o_mode.col_test     <= col_test;
            o_mode.neg_enable   <= neg_en;
            o_mode.neg_complete <= neg_done;
            o_mode.soft_reset   <= rst_busy;
        end
    end

endmodule : pbm_regs

// ### tb/pbm_regs_asserts.sv
`timescale 1ns/1ns
module pbm_regs_asserts #(
    parameter int NEG_CYCLES = 20
) (
    input wire logic                  i_clock,
    input wire logic                  i_sys_rst,
    input wire logic                  i_acc_valid,
    input wire pbm_pkg::pbm_acc_req_s i_acc_req,
    input wire logic                  i_speed_strap,
    input wire pbm_pkg::pbm_line_s    i_line,
    input wire pbm_pkg::pbm_acc_rsp_s o_acc_rsp,
    input wire pbm_pkg::pbm_mode_s    o_mode
);
    // ********************************
    // Access timing, decode, status and mode checks
    // ********************************
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic rd_req;
    logic wr_ctl;
    assign rd_req = i_acc_valid && !i_acc_req.write;
    assign wr_ctl = i_acc_valid && i_acc_req.write && i_acc_req.index == 5'h00;

    chk_done_pulse: assert property (i_acc_valid |=> o_acc_rsp.done)
        else $error("answer missing one cycle after request");
    chk_no_stray: assert property (!i_acc_valid |=> !o_acc_rsp.done)
        else $error("answer without request");
    chk_unmapped_read: assert property (rd_req && !(i_acc_req.index inside
        {[5'h00:5'h06], 5'h11, 5'h12, 5'h1B, [5'h1D:5'h1F]})
        |=> o_acc_rsp.unmapped && o_acc_rsp.rdata == 16'h0000)
        else $error("unmapped read not flagged");
    chk_status_fixed: assert property (rd_req && i_acc_req.index == 5'h01
        |=> (o_acc_rsp.rdata & 16'hFFC9) == 16'h7809)
        else $error("fixed status bits wrong");
    chk_soft_clear: assert property (wr_ctl && i_acc_req.wdata[15]
        |-> ##2 !o_mode.loopback && !o_mode.power_down && !o_mode.col_test)
        else $error("software reset left mode bits set");
    chk_ctl_follow: assert property (wr_ctl && !i_acc_req.wdata[15]
        |-> ##2 o_mode.loopback == $past(i_acc_req.wdata[14], 2)
        && o_mode.power_down == $past(i_acc_req.wdata[11], 2)
        && o_mode.col_test == $past(i_acc_req.wdata[7], 2))
        else $error("mode does not follow control write");
    chk_neg_result: assert property (o_mode.neg_enable && !o_mode.neg_complete
        |-> !o_mode.speed_100 && !o_mode.full_duplex)
        else $error("manual bits used while negotiating");
    chk_pd_no_neg: assert property (o_mode.power_down [*3] |-> !o_mode.neg_complete)
        else $error("negotiation complete in power down");
    chk_link_low: assert property (rd_req && i_acc_req.index == 5'h01
        && !i_line.link_up && !$past(i_line.link_up) && !$past(i_line.link_up, 2)
        && !$past(i_line.link_up, 3) |=> !o_acc_rsp.rdata[2])
        else $error("link bit high while link down");
endmodule : pbm_regs_asserts

// ### tb/pbm_mac_model.sv
`timescale 1ns/1ns
module pbm_mac_model (
    input  wire logic                  i_clock,
    input  wire pbm_pkg::pbm_acc_rsp_s i_rsp,
    output logic                       o_valid,
    output pbm_pkg::pbm_acc_req_s      o_req
);
    // ********************************
    // Indexed access master
    // ********************************
    initial begin
        o_valid = 1'b0;
        o_req = '0;
    end

    task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                          output logic [15:0] rd, output logic um);
        int n;
        n = 0;
        @(negedge i_clock);
        o_valid = 1'b1;
        o_req = '{write: wr, index: idx, wdata: wd};
        @(negedge i_clock);
        o_valid = 1'b0;
        // Released lines must not keep the last value
        o_req = ~o_req;
        while (i_rsp.done !== 1'b1 && n < 4) begin
            @(negedge i_clock);
            n++;
        end
        if (i_rsp.done !== 1'b1) begin
            $display("Error access answer expected 1 seen %b", i_rsp.done);
            test_pbm_regs.fail_count++;
        end
        rd = i_rsp.rdata;
        um = i_rsp.unmapped;
    endtask : access
endmodule : pbm_mac_model

// ### tb/test_pbm_regs.sv
`timescale 1ns/1ns
module test_pbm_regs;
    localparam int NEG_CYCLES = 20;
    logic                  i_clock;
    logic                  i_sys_rst;
    logic                  i_acc_valid;
    pbm_pkg::pbm_acc_req_s i_acc_req;
    logic                  i_speed_strap;
    pbm_pkg::pbm_line_s    i_line;
    pbm_pkg::pbm_acc_rsp_s o_acc_rsp;
    pbm_pkg::pbm_mode_s    o_mode;
    int                    fail_count = 0;
    int                    checks = 0;
    logic [31:0]           seed = 32'h0001_5FDF;
    logic [15:0]           m_ctrl;
    int                    m_rf, m_jab, m_link, m_neg;
    logic [15:0]           rd, wd, exp;
    logic                  um;

    always #50 i_clock = ~i_clock;

    pbm_regs #(.NEG_CYCLES(NEG_CYCLES)) u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_acc_valid(i_acc_valid), .i_acc_req(i_acc_req), .i_speed_strap(i_speed_strap),
        .i_line(i_line), .o_acc_rsp(o_acc_rsp), .o_mode(o_mode));
    pbm_mac_model u_mac (.i_clock(i_clock), .i_rsp(o_acc_rsp), .o_valid(i_acc_valid),
        .o_req(i_acc_req));

    // ********************************
    // Helpers and reference model
    // ********************************
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
        checks++;
        if (got !== e) begin
            $display("Error %s expected %h seen %h", what, e, got);
            fail_count++;
        end
    endtask : check

    task automatic rd_status(input string what);
        u_mac.access(1'b0, 5'h01, 16'h0000, rd, um);
        check(what, 16'h7809 | 16'((m_neg << 5) | (m_rf << 4) | (m_link << 2) | (m_jab << 1)), rd);
        m_rf = i_line.remote_fault;
        m_jab = i_line.jabber;
        m_link = i_line.link_up;
    endtask : rd_status

    task automatic do_reset(input logic strap);
        i_speed_strap = strap;
        i_sys_rst = 1'b1;
        repeat (5) @(negedge i_clock);
        i_sys_rst = 1'b0;
        m_ctrl = strap ? 16'h3000 : 16'h0000;
        {m_rf, m_jab, m_link, m_neg} = '0;
    endtask : do_reset

    task automatic finish_test();
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // ********************************
    // Scenarios
    // ********************************
    initial begin
        i_clock = 1'b0;
        i_line = '0;
        for (int s = 1; s >= 0; s--) begin
            do_reset(s[0]);
            u_mac.access(1'b0, 5'h00, 16'h0000, rd, um);
            check("control reset", m_ctrl, rd);
        end
        repeat (8) begin
            wd = 16'(next_rand()) & 16'h6DFF;
            m_ctrl = wd & 16'h6980;
            u_mac.access(1'b1, 5'h00, wd, rd, um);
            u_mac.access(1'b0, 5'h00, 16'h0000, rd, um);
            check("control", m_ctrl, rd);
            check("mode", 16'({wd[14], wd[13], wd[8], wd[11], wd[7], 3'b000}), 16'(o_mode));
        end
        for (int i = 2; i < 32; i++) begin
            u_mac.access(1'b1, 5'(i), 16'(next_rand()), rd, um);
            exp = (i == 2) ? pbm_pkg::IDENT_HIGH_VALUE : (i == 3) ? pbm_pkg::IDENT_LOW_VALUE : 16'h0000;
            u_mac.access(1'b0, 5'(i), 16'h0000, rd, um);
            check("index data", exp, rd);
            check("unmapped", 16'(!(i <= 6 || i == 17 || i == 18 || i == 27 || i >= 29)), 16'(um));
        end
        i_line.jabber = 1'b1;
        i_line.remote_fault = 1'b1;
        repeat (4) @(negedge i_clock);
        i_line.jabber = 1'b0;
        i_line.remote_fault = 1'b0;
        repeat (4) @(negedge i_clock);
        m_rf = 1;
        m_jab = 1;
        rd_status("status latched");
        rd_status("status refreshed");
        i_line.link_up = 1'b1;
        i_line.partner_100 = 1'b1;
        i_line.partner_full = 1'b1;
        repeat (4) @(negedge i_clock);
        rd_status("link first read");
        rd_status("link up");
        i_line.link_up = 1'b0;
        repeat (4) @(negedge i_clock);
        m_link = 0;
        rd_status("link drop");
        i_line.link_up = 1'b1;
        repeat (4) @(negedge i_clock);
        rd_status("link back");
        u_mac.access(1'b1, 5'h00, 16'h1200, rd, um);
        m_ctrl = 16'h1000;
        repeat (NEG_CYCLES + 10) @(negedge i_clock);
        m_neg = 1;
        u_mac.access(1'b0, 5'h00, 16'h0000, rd, um);
        check("restart clear", m_ctrl, rd);
        rd_status("negotiated");
        check("mode negotiated", 16'h0066, 16'(o_mode));
        u_mac.access(1'b1, 5'h00, 16'h1800, rd, um);
        repeat (5) @(negedge i_clock);
        m_neg = 0;
        rd_status("power down");
        check("mode power down", 16'h0014, 16'(o_mode));
        u_mac.access(1'b1, 5'h00, 16'h1000, rd, um);
        repeat (NEG_CYCLES + 10) @(negedge i_clock);
        m_neg = 1;
        rd_status("renegotiated");
        u_mac.access(1'b1, 5'h00, 16'hC000, rd, um);
        u_mac.access(1'b0, 5'h00, 16'h0000, rd, um);
        check("soft reset busy", 16'h8000, rd);
        check("mode soft reset", 16'h0001, 16'(o_mode));
        repeat (12) @(negedge i_clock);
        u_mac.access(1'b0, 5'h00, 16'h0000, rd, um);
        check("soft reset done", 16'h0000, rd);
        {m_rf, m_jab, m_link, m_neg} = '0;
        rd_status("status after soft reset");
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge i_clock);
        fail_count++;
        finish_test();
    end
endmodule : test_pbm_regs

bind pbm_regs pbm_regs_asserts #(.NEG_CYCLES(NEG_CYCLES)) u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_acc_valid(i_acc_valid), .i_acc_req(i_acc_req), .i_speed_strap(i_speed_strap),
    .i_line(i_line), .o_acc_rsp(o_acc_rsp), .o_mode(o_mode));
